/* File: cpwm_pkg.sv */
// Purpose: Shared constants and types of the cascaded three-channel PWM driver
// Assumes: sys_clk at 200 MHz; link clock made by the controller end
// Notes:   Every count derives from a time or a figure named here once
package cpwm_pkg;
    // ****************************************************************
    // Frame layout
    // ****************************************************************
    localparam int INIT_ZERO_BITS = 50;
    localparam int GRAY_BITS = 8;
    localparam int CHANNELS = 3;
    localparam int GRAY_FRAME_BITS = GRAY_BITS * CHANNELS;
    localparam int FRAME_BITS = GRAY_FRAME_BITS + 1;
    localparam logic [5:0] INIT_ZERO_CNT = 6'(INIT_ZERO_BITS);
    localparam logic [4:0] GRAY_LAST = 5'(GRAY_FRAME_BITS - 1);
    localparam logic [4:0] FRAME_LAST = 5'(FRAME_BITS - 1);
    localparam logic [7:0] INIT_LAST_BIT = 8'(INIT_ZERO_BITS - 1);
    localparam logic [7:0] FRAME_LAST_BIT = 8'(FRAME_BITS - 1);

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int SYS_CLK_KHZ = 200000;
    localparam int SYS_PERIOD_NS = 5;
    localparam int PWM_OSC_KHZ = 1030;
    localparam int PWM_TICK_DIV = SYS_CLK_KHZ / PWM_OSC_KHZ;
    localparam logic [7:0] PWM_TICK_LAST = 8'(PWM_TICK_DIV - 1);
    localparam int LINK_PERIOD_NS = 160;
    localparam int LINK_HALF_CYC = LINK_PERIOD_NS / (2 * SYS_PERIOD_NS);
    localparam logic [4:0] LINK_HALF_LAST = 5'(LINK_HALF_CYC - 1);

    // ****************************************************************
    // State types
    // ****************************************************************
    typedef enum logic [1:0] {RX_HUNT, RX_OWN, RX_PASS} cpwm_rx_st_t;
    typedef enum logic [2:0] {TX_IDLE, TX_INIT, TX_LOAD, TX_FRAME, TX_TRAIL} cpwm_tx_st_t;
endpackage

/* File: cpwm_link_if.sv */
// Purpose: Two-wire serial link between controller and first driver
// Assumes: Controller drives both wires; driver only listens
// Notes:   Clock idles low between updates
`timescale 1ns/1ps
`default_nettype none
interface cpwm_link_if;
    logic clk; // Serial clock, rising edge samples data
    logic dat; // Serial data, MSB first
    modport ctrl (output clk, output dat);
    modport drv (input clk, input dat);
endinterface
`default_nettype wire

/* File: cpwm_dev.sv */
// Purpose: Driver end: takes its own frame, forwards the rest, drives PWM
// Assumes: Link clock stands low outside updates; sys_clk stands in
//          for the internal PWM oscillator
// Notes:   Link logic runs on the upstream clock, PWM on sys_clk
// Overview of operation
// - Controller first sends fifty zero bits
// - Frames travel MSB first, assembled so
// - Data sampled on every rising link clock
// - First frame after start is ours
// - Frame: start bit one, 24 gray bits
// - Trailing pulses per chip commit new grays
// - Data held low during trailing pulses
// - Forwarded data regenerated against clock race
// - Each channel 8-bit linear PWM
// - Controller applies gamma for short sources; cpwm_host sends gray words unchanged
// - Drive select picks base or current drive
// - PWM timebase independent of link clock
`timescale 1ns/1ps
`default_nettype none
module cpwm_dev (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Upstream link
    cpwm_link_if.drv lnk,
    // Downstream link
    output wire logic serial_clock_out,
    output logic serial_data_out,
    // Drive mode strap and channel drives
    input wire logic output_drive_select,
    output logic [2:0] channel_drive_output,
    output logic [2:0] base_drive_output
);
    // ****************************************************************
    // Link domain receive
    // ****************************************************************
    cpwm_pkg::cpwm_rx_st_t st_ff, nxt_st;
    logic [5:0] zcnt_ff, nxt_zcnt;
    logic [4:0] bcnt_ff, nxt_bcnt;
    logic [23:0] shf_ff, nxt_shf;
    logic [23:0] hold_ff, nxt_hold;
    logic tgl_ff, nxt_tgl;
    logic fwd_ff, nxt_fwd;
    logic dout_ff;

    // Frame tracking, one bit per rising link edge
    always_comb begin
        nxt_st = st_ff;
        nxt_zcnt = zcnt_ff;
        nxt_bcnt = bcnt_ff;
        nxt_shf = shf_ff;
        nxt_hold = hold_ff;
        nxt_tgl = tgl_ff;
        nxt_fwd = lnk.dat; // Pass through by default
        unique case (st_ff)
            cpwm_pkg::RX_HUNT: begin
                if (lnk.dat) begin
                    nxt_zcnt = 6'h00;
                    // Start bit after the zero run opens our frame
                    if (zcnt_ff == cpwm_pkg::INIT_ZERO_CNT) begin
                        nxt_st = cpwm_pkg::RX_OWN;
                        nxt_bcnt = 5'h00;
                        nxt_fwd = 1'b0;
                    end
                end else if (zcnt_ff != cpwm_pkg::INIT_ZERO_CNT) begin
                    nxt_zcnt = zcnt_ff + 6'h01; // Saturates at the marker length
                end
            end
            cpwm_pkg::RX_OWN: begin
                // Our bits are swallowed; downstream sees zeros instead
                nxt_fwd = 1'b0;
                nxt_shf = {shf_ff[22:0], lnk.dat}; // MSB arrives first
                if (bcnt_ff == cpwm_pkg::GRAY_LAST) begin
                    nxt_st = cpwm_pkg::RX_PASS;
                    nxt_bcnt = 5'h00;
                end else begin
                    nxt_bcnt = bcnt_ff + 5'h01;
                end
            end
            cpwm_pkg::RX_PASS: begin
                // A zero where a start bit belongs is a trailing pulse
                if (bcnt_ff == 5'h00 && !lnk.dat) begin
                    nxt_hold = shf_ff;
                    nxt_tgl = ~tgl_ff;
                    nxt_st = cpwm_pkg::RX_HUNT;
                    nxt_zcnt = 6'h01;
                end else if (bcnt_ff == cpwm_pkg::FRAME_LAST) begin
                    nxt_bcnt = 5'h00;
                end else begin
                    nxt_bcnt = bcnt_ff + 5'h01;
                end
            end
        endcase
    end

    // Link domain registers; link clock may stop, state simply waits
    always_ff @(posedge lnk.clk or posedge rst) begin
        if (rst) begin
            st_ff <= cpwm_pkg::RX_HUNT;
            zcnt_ff <= 6'h00;
            bcnt_ff <= 5'h00;
            shf_ff <= 24'h000000;
            hold_ff <= 24'h000000;
            tgl_ff <= 1'b0;
            fwd_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            zcnt_ff <= nxt_zcnt;
            bcnt_ff <= nxt_bcnt;
            shf_ff <= nxt_shf;
            hold_ff <= nxt_hold;
            tgl_ff <= nxt_tgl;
            fwd_ff <= nxt_fwd;
        end
    end

    // ****************************************************************
    // Regenerated downstream link
    // ****************************************************************
    // Data launched on the falling edge: a half period of setup and
    // hold at the next chip whatever the cable skew
    always_ff @(negedge lnk.clk or posedge rst) begin
        if (rst) begin
            dout_ff <= 1'b0;
        end else begin
            dout_ff <= fwd_ff;
        end
    end

    // Clock is rebuffered, not retimed, so it cannot race the data
    assign serial_clock_out = lnk.clk;
    assign serial_data_out = dout_ff;

    // ****************************************************************
    // Crossing into the PWM domain
    // ****************************************************************
    logic [2:0] tsync_ff, nxt_tsync;
    logic [1:0] msync_ff, nxt_msync;
    logic [23:0] gray_ff, nxt_gray;

    // Commit toggle through two flops; hold_ff is static for a frame
    // or more after each toggle, so the word is safe to copy
    always_comb begin
        nxt_tsync = {tsync_ff[1:0], tgl_ff};
        nxt_msync = {msync_ff[0], output_drive_select};
        nxt_gray = gray_ff;
        if (tsync_ff[2] != tsync_ff[1]) begin
            nxt_gray = hold_ff;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tsync_ff <= 3'h0;
            msync_ff <= 2'h3;
            gray_ff <= 24'h000000;
        end else begin
            tsync_ff <= nxt_tsync;
            msync_ff <= nxt_msync;
            gray_ff <= nxt_gray;
        end
    end

    // ****************************************************************
    // PWM engine
    // ****************************************************************
    logic [7:0] pre_ff, nxt_pre;
    logic [7:0] pcnt_ff, nxt_pcnt;
    logic [2:0] cdrv_ff, nxt_cdrv;
    logic [2:0] bdrv_ff, nxt_bdrv;
    logic [2:0] pwm_on;

    // Timebase from sys_clk only, never the link clock
    always_comb begin
        nxt_pre = pre_ff + 8'h01;
        nxt_pcnt = pcnt_ff;
        if (pre_ff == cpwm_pkg::PWM_TICK_LAST) begin
            nxt_pre = 8'h00;
            nxt_pcnt = pcnt_ff + 8'h01; // 256 steps per period
        end
        // On while count below level: 0 never on, 255 on 255 of 256
        for (int i = 0; i < cpwm_pkg::CHANNELS; i++) begin
            pwm_on[i] = pcnt_ff < gray_ff[23 - 8 * i -: 8];
        end
        // Low strap selects base drive of an outside transistor
        nxt_cdrv = msync_ff[1] ? pwm_on : 3'h0;
        nxt_bdrv = msync_ff[1] ? 3'h0 : pwm_on;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pre_ff <= 8'h00;
            pcnt_ff <= 8'h00;
            cdrv_ff <= 3'h0;
            bdrv_ff <= 3'h0;
        end else begin
            pre_ff <= nxt_pre;
            pcnt_ff <= nxt_pcnt;
            cdrv_ff <= nxt_cdrv;
            bdrv_ff <= nxt_bdrv;
        end
    end

    assign channel_drive_output = cdrv_ff;
    assign base_drive_output = bdrv_ff;
endmodule
`default_nettype wire

/* File: cpwm_host.sv */
// Purpose: Controller end: sends marker, one frame per chip, trailing pulses
// Assumes: User offers gray words in chain order
// Notes:   Link clock is sys_clk divided; it stands low when idle
`timescale 1ns/1ps
`default_nettype none
module cpwm_host (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Link toward the first chip
    cpwm_link_if.ctrl lnk,
    // Update request
    input wire logic start,
    input wire logic [7:0] chip_count,
    output logic busy,
    // Gray words, channel 1 in the top byte
    input wire logic [23:0] gray_data,
    input wire logic gray_valid,
    output logic gray_ready
);
    // ****************************************************************
    // Transmit sequencer
    // ****************************************************************
    cpwm_pkg::cpwm_tx_st_t st_ff, nxt_st;
    logic [4:0] half_ff, nxt_half;
    logic clk_ff, nxt_clk;
    logic dat_ff, nxt_dat;
    logic [7:0] bit_ff, nxt_bit;
    logic [7:0] chip_ff, nxt_chip;
    logic [7:0] num_ff, nxt_num;
    logic [24:0] sh_ff, nxt_sh;
    logic busy_ff, nxt_busy;
    logic rdy_ff, nxt_rdy;
    logic tick;

    always_comb begin
        nxt_st = st_ff;
        nxt_half = half_ff;
        nxt_clk = clk_ff;
        nxt_dat = dat_ff;
        nxt_bit = bit_ff;
        nxt_chip = chip_ff;
        nxt_num = num_ff;
        nxt_sh = sh_ff;
        nxt_busy = busy_ff;
        nxt_rdy = 1'b0;
        tick = half_ff == cpwm_pkg::LINK_HALF_LAST;
        unique case (st_ff)
            cpwm_pkg::TX_IDLE: begin
                if (start && chip_count != 8'h00) begin
                    nxt_num = chip_count;
                    nxt_chip = 8'h00;
                    nxt_bit = cpwm_pkg::INIT_LAST_BIT; // Marker of zeros
                    nxt_half = 5'h00;
                    nxt_dat = 1'b0;
                    nxt_busy = 1'b1;
                    nxt_st = cpwm_pkg::TX_INIT;
                end
            end
            cpwm_pkg::TX_LOAD: begin
                // Clock stays low until a word is offered
                if (gray_valid) begin
                    nxt_sh = {1'b1, gray_data}; // Start bit then grays
                    nxt_dat = 1'b1;
                    nxt_bit = cpwm_pkg::FRAME_LAST_BIT;
                    nxt_rdy = 1'b1;
                    nxt_half = 5'h00;
                    nxt_st = cpwm_pkg::TX_FRAME;
                end
            end
            cpwm_pkg::TX_INIT, cpwm_pkg::TX_FRAME, cpwm_pkg::TX_TRAIL: begin
                nxt_half = tick ? 5'h00 : half_ff + 5'h01;
                if (tick) begin
                    nxt_clk = ~clk_ff;
                    // Falling edge ends a bit; data changes here, far from
                    // the rising sample edge
                    if (clk_ff) begin
                        nxt_bit = bit_ff - 8'h01;
                        nxt_sh = {sh_ff[23:0], 1'b0}; // MSB first
                        nxt_dat = (st_ff == cpwm_pkg::TX_FRAME) ? sh_ff[23] : 1'b0;
                        if (bit_ff == 8'h00) begin
                            nxt_dat = 1'b0; // Low through trailing pulses
                            if (st_ff == cpwm_pkg::TX_INIT) begin
                                nxt_st = cpwm_pkg::TX_LOAD;
                            end else if (st_ff == cpwm_pkg::TX_FRAME) begin
                                // Frames go nearest chip first
                                nxt_chip = chip_ff + 8'h01;
                                if (chip_ff + 8'h01 == num_ff) begin
                                    nxt_st = cpwm_pkg::TX_TRAIL;
                                    nxt_bit = num_ff - 8'h01; // One pulse per chip
                                end else begin
                                    nxt_st = cpwm_pkg::TX_LOAD;
                                end
                            end else begin
                                nxt_st = cpwm_pkg::TX_IDLE;
                                nxt_busy = 1'b0;
                            end
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_ff <= cpwm_pkg::TX_IDLE;
            half_ff <= 5'h00;
            clk_ff <= 1'b0;
            dat_ff <= 1'b0;
            bit_ff <= 8'h00;
            chip_ff <= 8'h00;
            num_ff <= 8'h00;
            sh_ff <= 25'h0;
            busy_ff <= 1'b0;
            rdy_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            half_ff <= nxt_half;
            clk_ff <= nxt_clk;
            dat_ff <= nxt_dat;
            bit_ff <= nxt_bit;
            chip_ff <= nxt_chip;
            num_ff <= nxt_num;
            sh_ff <= nxt_sh;
            busy_ff <= nxt_busy;
            rdy_ff <= nxt_rdy;
        end
    end

    // Outputs straight from flops
    assign lnk.clk = clk_ff;
    assign lnk.dat = dat_ff;
    assign busy = busy_ff;
    assign gray_ready = rdy_ff;
endmodule
`default_nettype wire

/* File: cpwm_sva.sv */
// Purpose: Concurrent checks on the two wires between controller and first driver
// Assumes: Link clock made from sys_clk by the controller, 16 high / 16 low
// Notes:   Helper counters track rises per update and the idle gap after it
`timescale 1ns/1ps
`default_nettype none
module cpwm_sva (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Link wires
    input wire logic clk,
    input wire logic dat
);
    // ****************************************************************
    // Helper counters
    // ****************************************************************
    logic [7:0] rise_cnt_ff, nxt_rise_cnt;
    logic [5:0] low_cnt_ff, nxt_low_cnt;
    logic clk_q_ff, last_bit_ff, nxt_last_bit;

    // Rises since the last idle gap; checked at 40 low cycles, cleared at 41
    always_comb begin
        nxt_rise_cnt = rise_cnt_ff;
        nxt_last_bit = last_bit_ff;
        nxt_low_cnt = clk ? 6'h00 : low_cnt_ff + ((low_cnt_ff == 6'h3F) ? 6'h00 : 6'h01);
        if (clk && !clk_q_ff) begin
            nxt_rise_cnt = rise_cnt_ff + ((rise_cnt_ff == 8'hFF) ? 8'h00 : 8'h01);
            nxt_last_bit = dat;
        end else if (low_cnt_ff == 6'h29) begin
            nxt_rise_cnt = 8'h00;
        end
    end

    // Registers only
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rise_cnt_ff <= 8'h00;
            low_cnt_ff <= 6'h00;
            clk_q_ff <= 1'b0;
            last_bit_ff <= 1'b0;
        end else begin
            rise_cnt_ff <= nxt_rise_cnt;
            low_cnt_ff <= nxt_low_cnt;
            clk_q_ff <= clk;
            last_bit_ff <= nxt_last_bit;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    a_clk_high_width: assert property ($rose(clk) |-> clk[*8] ##1 clk[*8] ##1 !clk)
        else $error("link clock high phase not 16 cycles");
    a_clk_low_width: assert property ($fell(clk) |-> !clk[*8] ##1 !clk[*8])
        else $error("link clock low phase shorter than 16 cycles");
    a_dat_still_high: assert property (clk && $past(clk) |-> $stable(dat))
        else $error("data moved while link clock high");
    a_dat_setup_time: assert property ($rose(clk) |-> dat == $past(dat, 8))
        else $error("data not settled before rising link clock");
    a_marker_zeros: assert property ($rose(clk) && rise_cnt_ff < 8'h32 |-> !dat)
        else $error("marker bit not zero");
    a_first_start_bit: assert property ($rose(clk) && rise_cnt_ff == 8'h32 |-> dat)
        else $error("frame after marker lacks start bit");
    a_trail_low: assert property (low_cnt_ff == 6'h28 |-> !last_bit_ff)
        else $error("last trailing pulse carried a one");
    a_bit_total: assert property (low_cnt_ff == 6'h28 && rise_cnt_ff != 8'h00 |->
        rise_cnt_ff >= 8'h4C && ((int'(rise_cnt_ff) - 50) % 26) == 0)
        else $error("update bit count not marker plus 26 per chip");

    // Main scenarios reached
    cover property ($rose(clk) && rise_cnt_ff == 8'h32 && dat);
    cover property ($rose(clk) && rise_cnt_ff == 8'h64 && !dat);
    cover property (low_cnt_ff == 6'h28 && rise_cnt_ff == 8'h66);
endmodule
`default_nettype wire

/* File: cascaded_three_channel_pwm_driver_tb_top.sv */
// Purpose: Controller feeding a chain of two drivers; wire and PWM duty checks
// Assumes: Second driver hangs on the first one's forwarded clock and data
// Notes:   Duty is counted over one full PWM period, so phase does not matter
`timescale 1ns/1ps
`default_nettype none
module cascaded_three_channel_pwm_driver_tb_top;
    // ****************************************************************
    // Signals and instances
    // ****************************************************************
    // Levels already span full 8 bits, so no gamma step is needed
    localparam logic [23:0] WORD_A = 24'h0080FF;
    localparam logic [23:0] WORD_B = 24'hFF0140;
    localparam int PER = cpwm_pkg::PWM_TICK_DIV * 256;
    logic sys_clk, rst, start, busy, gray_valid, gray_ready, fwd_clk, fwd_dat;
    logic fwd2_clk, fwd2_dat;
    logic [7:0] chip_count;
    logic [23:0] gray_data;
    logic [2:0] drv0, base0, drv1, base1;
    logic [101:0] exp_bits;
    logic up[$];
    logic dn[$];
    int n_errors, checks_done, cyc, hi[12];
    int n_taken, rises2, ones2;
    cpwm_link_if link0 ();
    cpwm_link_if link1 ();
    assign link1.clk = fwd_clk;
    assign link1.dat = fwd_dat;

    cpwm_host cpwm_host_inst (.sys_clk(sys_clk), .rst(rst), .lnk(link0.ctrl), .start(start),
        .chip_count(chip_count), .busy(busy), .gray_data(gray_data),
        .gray_valid(gray_valid), .gray_ready(gray_ready));
    cpwm_dev cpwm_dev_inst (.sys_clk(sys_clk), .rst(rst), .lnk(link0.drv),
        .serial_clock_out(fwd_clk), .serial_data_out(fwd_dat), .output_drive_select(1'b1),
        .channel_drive_output(drv0), .base_drive_output(base0));
    cpwm_dev cpwm_dev_inst_1 (.sys_clk(sys_clk), .rst(rst), .lnk(link1.drv),
        .serial_clock_out(fwd2_clk), .serial_data_out(fwd2_dat), .output_drive_select(1'b0),
        .channel_drive_output(drv1), .base_drive_output(base1));
    cpwm_sva cpwm_sva_inst (.sys_clk(sys_clk), .rst(rst), .clk(link0.clk), .dat(link0.dat));

    // ****************************************************************
    // Clock, timeout, wire capture, word feed
    // ****************************************************************
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // Whole run needs about 53k cycles
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 80000) begin
            n_errors++;
            results();
        end
    end
    always @(posedge link0.clk) up.push_back(link0.dat);
    always @(posedge link1.clk) dn.push_back(link1.dat);
    // Last chip owns the only frame left, so only zeros leave it
    always @(posedge fwd2_clk) begin
        rises2++;
        ones2 += int'(fwd2_dat !== 1'b0);
    end
    // Nearest chip's word first, next word once the first is taken
    always @(posedge sys_clk) begin
        if (gray_ready === 1'b1) begin
            gray_data <= WORD_B;
            n_taken++;
        end
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
            n_errors++;
        end
    endtask
    // One start pulse with the given chip count
    task automatic request(input logic [7:0] n);
        @(posedge sys_clk);
        start <= 1'b1;
        chip_count <= n;
        @(posedge sys_clk);
        start <= 1'b0;
    endtask
    task automatic results();
        if (n_errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        // Reset rises after time zero so every async flop sees the edge
        rst = 1'b0;
        start = 1'b0;
        chip_count = 8'h00;
        gray_data = WORD_A;
        gray_valid = 1'b1;
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        // Zero chips is refused: no busy, no clock
        request(8'h00);
        repeat (3) @(negedge sys_clk);
        check(busy, 1'b0);
        check(up.size(), 0);
        // Two-chip update, with a stray start while busy
        request(8'h02);
        @(negedge sys_clk);
        check(busy, 1'b1);
        repeat (200) @(posedge sys_clk);
        request(8'h05);
        for (int i = 0; i < 6000 && busy !== 1'b0; i++) @(negedge sys_clk);
        check(busy, 1'b0);
        repeat (20) @(negedge sys_clk);
        // Upstream wire: marker, two frames MSB first, two low trailing pulses
        exp_bits = {50'h0, 1'b1, WORD_A, 1'b1, WORD_B, 2'b00};
        check(up.size(), 102);
        for (int k = 0; k < 102 && k < up.size(); k++)
            check(up[k], exp_bits[101 - k]);
        // Downstream: one bit later, own frame replaced by zeros
        check(dn.size(), 102);
        for (int k = 1; k < 102 && k < dn.size(); k++)
            check(dn[k], (k > 50 && k < 76) ? 1'b0 : exp_bits[102 - k]);
        check(rises2, 102);
        check(ones2, 0);
        check(n_taken, 2);
        // Count high cycles over one PWM period on all twelve drive lines
        for (int i = 0; i < PER; i++) begin
            @(negedge sys_clk);
            for (int c = 0; c < 3; c++) begin
                hi[c] += (drv0[c] === 1'b1);
                hi[3 + c] += (base0[c] === 1'b1);
                hi[6 + c] += (drv1[c] === 1'b1);
                hi[9 + c] += (base1[c] === 1'b1);
            end
        end
        for (int c = 0; c < 3; c++) begin
            check(hi[c], WORD_A[23 - 8 * c -: 8] * cpwm_pkg::PWM_TICK_DIV);
            check(hi[3 + c], 0);
            check(hi[6 + c], 0);
            check(hi[9 + c], WORD_B[23 - 8 * c -: 8] * cpwm_pkg::PWM_TICK_DIV);
        end
        results();
    end
endmodule
`default_nettype wire
